// ==== core/adcc_params.svh ====
// Register map, field positions, reset values and timing counts of the converter control
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH
// Byte addresses of the APB registers
`define ADCC_OFF_CTRL 8'h00
`define ADCC_OFF_RESH 8'h04
`define ADCC_OFF_CFG 8'h08
`define ADCC_OFF_DLY 8'h0C
`define ADCC_OFF_ISTAT 8'h10
`define ADCC_OFF_ICLR 8'h14
`define ADCC_OFF_IEN 8'h18
`define ADCC_OFF_ENA 8'h1C
// Control register field positions
`define ADCC_CTRL_HWEN 5
`define ADCC_CTRL_DONE 4
`define ADCC_CTRL_BUSY 3
// Reset values
`define ADCC_CFG_RST 8'h40
`define ADCC_DLY_RST 8'h00
// Machine clock is the CPU clock divided by this plus one
`define ADCC_MCLK_DIV 2'h3
// Interrupt event bits
`define ADCC_EV_DONE 0
`define ADCC_EV_ABORT 1
`define ADCC_EV_W 2
`endif

// ==== core/adcc_pkg.sv ====
// Types shared by the converter control logic
package adcc_pkg;
	// Control register layout
	typedef struct packed {
		logic [1:0] res_lo;
		logic hw_trigger_enable;
		logic conv_done_flag;
		logic conv_start_busy;
		logic [2:0] channel_select;
	} adcc_ctrl_t;
	// Configuration register layout
	typedef struct packed {
		logic [1:0] clock_divider_select;
		logic [1:0] trigger_type_select;
		logic delay_prescale;
		logic continuous_mode_enable;
		logic [1:0] pwm_trigger_source;
	} adcc_cfg_t;
	// Requests to the analog core
	typedef struct packed {
		logic start;
		logic abort;
		logic clk_tick;
		logic [2:0] channel;
	} adcc_core_req_t;
	// Sequencer states, Gray along idle, delay, convert
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DELAY = 2'h1,
		ST_CONV = 2'h3
	} adcc_state_t;
endpackage

// ==== core/adcc_top.sv ====
// Converter control: APB registers, trigger selection, conversion sequencing
//
// Operation
// - Result MSBs to high byte, LSBs to control
// - Trigger enable low: software start only
// - Trigger enable high: software, pin, PWM edges
// - PWM triggers need type bit 1 and enable
// - Done flag set on result; raises interrupt
// - Start bit held while busy, cleared after done
// - Clear done with start: new conversion allowed
// - Clearing start bit aborts conversion
// - No new start while busy or done (continuous mode ignores done)
// - Status pair decodes idle, busy, complete
// - Channel code n routes analog input n
// - Continuous mode bit enables continuous conversion
// - PWM source selects channel 0,2,4,6
// - PWM trigger delay: count plus one ticks
`timescale 1ns/10ps
`include "adcc_params.svh"
module adcc_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger pins, asynchronous
	input wire logic external_start_pin,
	input wire logic [3:0] pwm_ch,
	input wire logic pwm_centre,
	// Analog core, same clock
	input wire logic conv_ready,
	input wire logic [9:0] conv_result,
	output adcc_pkg::adcc_core_req_t core_req,
	// Interrupt
	output logic irq
);
	import adcc_pkg::*;

	// Registers and their next values
	adcc_ctrl_t ctrl_reg, ctrl_next; // Control and status
	logic [7:0] resh_reg, resh_next; // Result high byte
	adcc_cfg_t cfg_reg, cfg_next; // Configuration
	logic [7:0] dly_reg, dly_next; // Trigger delay count
	logic ena_reg, ena_next; // Converter enable
	logic [`ADCC_EV_W-1:0] ist_reg, ist_next; // Sticky events
	logic [`ADCC_EV_W-1:0] ien_reg, ien_next; // Event enables
	logic irq_reg, irq_next;
	adcc_state_t st_reg, st_next; // Sequencer state
	logic [7:0] dcnt_reg, dcnt_next; // Delay down counter
	logic [1:0] mcnt_reg, mcnt_next; // Machine clock divider
	logic pre_reg, pre_next; // Delay prescale phase
	logic [2:0] ccnt_reg, ccnt_next; // Converter clock divider
	adcc_core_req_t req_reg, req_next;
	logic [31:0] rd_reg, rd_next;
	logic rdy_reg, rdy_next;
	logic err_reg, err_next;
	// Pin synchronisers: stage one, stage two, previous
	logic [5:0] s1_reg, s2_reg, s3_reg;

	// Decoded helpers
	logic acc; // Access phase seen
	logic wr; // Write takes effect
	logic mapped; // Address hits a register
	logic [5:0] rise, fall; // Synchronised edges
	logic pwm_rise, pwm_fall; // Edges of the chosen channel
	logic pwm_hit, pin_hit; // Qualified hardware triggers
	logic sw_start, sw_abort; // Software start and abort
	logic can_start; // Start allowed now
	logic mtick, dtick; // Machine and delay ticks
	logic [2:0] cmask; // Converter clock mask

	// Two flops on every pin before any logic reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 6'h00;
			s2_reg <= 6'h00;
			s3_reg <= 6'h00;
		end else begin
			s1_reg <= {pwm_centre, pwm_ch, external_start_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Edge detection on the second stage against its history
	always_comb begin
		rise = s2_reg & ~s3_reg;
		fall = ~s2_reg & s3_reg;
		pwm_rise = rise[3'(cfg_reg.pwm_trigger_source) + 3'h1];
		pwm_fall = fall[3'(cfg_reg.pwm_trigger_source) + 3'h1];
	end

	// Trigger qualification
	always_comb begin
		pin_hit = 1'b0;
		pwm_hit = 1'b0;
		// Hardware sources only while enabled by software
		if (ctrl_reg.hw_trigger_enable && ena_reg) begin
			unique case (cfg_reg.trigger_type_select)
				2'h0: pin_hit = rise[0];
				2'h1: pwm_hit = 1'b0; // Upper type bit low: PWM gated off
				2'h2: pwm_hit = pwm_fall;
				2'h3: pwm_hit = rise[5]; // Centre point, any channel
			endcase
		end
		// Rising PWM edge kept for completeness, never selected: the guard is constant false
		if (1'b0) begin
			pwm_hit = pwm_rise;
		end
	end

	// Machine clock and delay prescale ticks
	always_comb begin
		mcnt_next = mcnt_reg + 2'h1;
		mtick = (mcnt_reg == `ADCC_MCLK_DIV);
		pre_next = mtick ? ~pre_reg : pre_reg;
		dtick = mtick && (!cfg_reg.delay_prescale || pre_reg);
	end

	// Converter clock divider
	always_comb begin
		unique case (cfg_reg.clock_divider_select)
			2'h0: cmask = 3'h0;
			2'h1: cmask = 3'h1;
			2'h2: cmask = 3'h3;
			2'h3: cmask = 3'h7;
		endcase
		ccnt_next = ccnt_reg + 3'h1;
	end

	// APB decode
	always_comb begin
		acc = psel && penable;
		wr = acc && pwrite && rdy_reg;
		unique case (paddr)
			`ADCC_OFF_CTRL, `ADCC_OFF_RESH, `ADCC_OFF_CFG, `ADCC_OFF_DLY,
			`ADCC_OFF_ISTAT, `ADCC_OFF_ICLR, `ADCC_OFF_IEN, `ADCC_OFF_ENA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Register file, sequencer and interrupt next state
	always_comb begin
		ctrl_next = ctrl_reg;
		resh_next = resh_reg;
		cfg_next = cfg_reg;
		dly_next = dly_reg;
		ena_next = ena_reg;
		ien_next = ien_reg;
		ist_next = ist_reg;
		st_next = st_reg;
		dcnt_next = dcnt_reg;
		sw_start = 1'b0;
		sw_abort = 1'b0;
		req_next = req_reg;
		req_next.start = 1'b0;
		req_next.abort = 1'b0;
		req_next.clk_tick = ((ccnt_reg & cmask) == 3'h0);
		// Register writes
		if (wr) begin
			unique case (paddr)
				`ADCC_OFF_CTRL: begin
					ctrl_next.hw_trigger_enable = pwdata[`ADCC_CTRL_HWEN];
					ctrl_next.channel_select = pwdata[2:0];
					// Only software clears the done flag
					if (!pwdata[`ADCC_CTRL_DONE]) begin
						ctrl_next.conv_done_flag = 1'b0;
					end
					if (pwdata[`ADCC_CTRL_BUSY] && !ctrl_reg.conv_start_busy) begin
						sw_start = 1'b1;
					end
					if (!pwdata[`ADCC_CTRL_BUSY] && ctrl_reg.conv_start_busy) begin
						sw_abort = 1'b1;
					end
				end
				`ADCC_OFF_CFG: cfg_next = adcc_cfg_t'(pwdata[7:0]);
				`ADCC_OFF_DLY: dly_next = pwdata[7:0];
				`ADCC_OFF_ICLR: ist_next = ist_reg & ~pwdata[`ADCC_EV_W-1:0];
				`ADCC_OFF_IEN: ien_next = pwdata[`ADCC_EV_W-1:0];
				`ADCC_OFF_ENA: ena_next = pwdata[0];
				default: begin
				end
			endcase
		end
		// Start allowed only from idle with done clear, unless continuous
		can_start = cfg_reg.continuous_mode_enable || !ctrl_next.conv_done_flag;
		unique case (st_reg)
			ST_IDLE: begin
				if (can_start && pwm_hit) begin
					// PWM start waits the programmed delay
					st_next = ST_DELAY;
					dcnt_next = dly_reg;
					ctrl_next.conv_start_busy = 1'b1;
				end else if (can_start && (sw_start || pin_hit)) begin
					st_next = ST_CONV;
					req_next.start = 1'b1;
					req_next.channel = ctrl_next.channel_select;
					ctrl_next.conv_start_busy = 1'b1;
				end
			end
			ST_DELAY: begin
				if (sw_abort) begin
					st_next = ST_IDLE;
					ctrl_next.conv_start_busy = 1'b0;
					ist_next[`ADCC_EV_ABORT] = 1'b1;
				end else if (dtick) begin
					if (dcnt_reg == 8'h00) begin
						st_next = ST_CONV;
						req_next.start = 1'b1;
						req_next.channel = ctrl_reg.channel_select;
					end else begin
						dcnt_next = dcnt_reg - 8'h01;
					end
				end
			end
			ST_CONV: begin
				if (sw_abort) begin
					st_next = ST_IDLE;
					req_next.abort = 1'b1;
					ctrl_next.conv_start_busy = 1'b0;
					ist_next[`ADCC_EV_ABORT] = 1'b1;
				end else if (conv_ready) begin
					// Result split across two registers
					resh_next = conv_result[9:2];
					ctrl_next.res_lo = conv_result[1:0];
					ctrl_next.conv_done_flag = 1'b1; // set wins over clear
					ist_next[`ADCC_EV_DONE] = 1'b1;
					if (cfg_reg.continuous_mode_enable) begin
						// Next conversion follows at once
						req_next.start = 1'b1;
						req_next.channel = ctrl_next.channel_select;
					end else begin
						st_next = ST_IDLE;
						ctrl_next.conv_start_busy = 1'b0;
					end
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
		irq_next = |(ist_next & ien_next);
	end

	// APB answer: one wait state, read data captured on the same edge that raises ready
	always_comb begin
		rdy_next = acc && !rdy_reg;
		err_next = acc && !rdy_reg && !mapped;
		rd_next = rd_reg;
		if (acc && !rdy_reg) begin
			rd_next = 32'h0000_0000;
			unique case (paddr)
				`ADCC_OFF_CTRL: rd_next[7:0] = ctrl_reg;
				`ADCC_OFF_RESH: rd_next[7:0] = resh_reg;
				`ADCC_OFF_CFG: rd_next[7:0] = cfg_reg;
				`ADCC_OFF_DLY: rd_next[7:0] = dly_reg;
				`ADCC_OFF_ISTAT: rd_next[`ADCC_EV_W-1:0] = ist_reg;
				`ADCC_OFF_IEN: rd_next[`ADCC_EV_W-1:0] = ien_reg;
				`ADCC_OFF_ENA: rd_next[0] = ena_reg;
				default: rd_next = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= adcc_ctrl_t'(8'h00);
			resh_reg <= 8'h00;
			cfg_reg <= adcc_cfg_t'(`ADCC_CFG_RST);
			dly_reg <= `ADCC_DLY_RST;
			ena_reg <= 1'b0;
			ist_reg <= '0;
			ien_reg <= '0;
			irq_reg <= 1'b0;
			st_reg <= ST_IDLE;
			dcnt_reg <= 8'h00;
			mcnt_reg <= 2'h0;
			pre_reg <= 1'b0;
			ccnt_reg <= 3'h0;
			req_reg <= adcc_core_req_t'(6'h00);
			rd_reg <= 32'h0000_0000;
			rdy_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			resh_reg <= resh_next;
			cfg_reg <= cfg_next;
			dly_reg <= dly_next;
			ena_reg <= ena_next;
			ist_reg <= ist_next;
			ien_reg <= ien_next;
			irq_reg <= irq_next;
			st_reg <= st_next;
			dcnt_reg <= dcnt_next;
			mcnt_reg <= mcnt_next;
			pre_reg <= pre_next;
			ccnt_reg <= ccnt_next;
			req_reg <= req_next;
			rd_reg <= rd_next;
			rdy_reg <= rdy_next;
			err_reg <= err_next;
		end
	end

	// Outputs straight from flops
	assign prdata = rd_reg;
	assign pready = rdy_reg;
	assign pslverr = err_reg;
	assign core_req = req_reg;
	assign irq = irq_reg;
endmodule

// ==== sim/adcc_core_model.sv ====
// Behavioural analog core answering conversion requests
`timescale 1ns/10ps
module adcc_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requests and answer set-up
	input wire adcc_pkg::adcc_core_req_t core_req,
	input wire logic [7:0] lat,
	input wire logic [9:0] value,
	// Answer
	output logic conv_ready,
	output logic [9:0] conv_result
);
	import adcc_pkg::*;
	logic [7:0] cnt; // Cycles left, zero when idle
	// Count down after a start, answer once, drop on abort
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			conv_ready <= 1'h0;
			conv_result <= 10'h000;
		end else begin
			conv_ready <= 1'h0;
			conv_result <= ~conv_result; // Result is not held past its pulse
			if (core_req.abort) begin
				cnt <= 8'h00;
			end else if (core_req.start) begin
				cnt <= lat;
			end else if (cnt == 8'h01) begin
				cnt <= 8'h00;
				conv_ready <= 1'h1;
				conv_result <= value;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// ==== sim/adcc_monitor.sv ====
// Port checker of the converter control
`timescale 1ns/10ps
module adcc_monitor (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Analog core
	input wire logic conv_ready,
	input wire adcc_pkg::adcc_core_req_t core_req
);
	import adcc_pkg::*;
	logic busy_reg; // Conversion in flight at the core
	logic busy_next;
	// Set by start, cleared by answer or abort
	always_comb begin
		busy_next = busy_reg;
		if (core_req.start) begin
			busy_next = 1'h1;
		end else if (conv_ready || core_req.abort) begin
			busy_next = 1'h0;
		end
	end
	// Register the flight state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'h0;
		end else begin
			busy_reg <= busy_next;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_wait_a: assert property ($rose(penable) && psel |=> pready)
		else $error("pready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	start_pulse_a: assert property (core_req.start |=> !core_req.start)
		else $error("start longer than one cycle");
	start_blocked_a: assert property (core_req.start |-> !busy_reg)
		else $error("start while converting");
	abort_cause_a: assert property (core_req.abort |-> busy_reg && !core_req.start)
		else $error("abort while idle");
	abort_pulse_a: assert property (core_req.abort |=> !core_req.abort)
		else $error("abort longer than one cycle");
	chan_hold_a: assert property (busy_reg && !conv_ready && !core_req.abort
		|=> $stable(core_req.channel))
		else $error("channel moved during conversion");
endmodule
bind adcc_top adcc_monitor adcc_monitor_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .conv_ready, .core_req);

// ==== sim/tb_top.sv ====
// Testbench of the converter control
`timescale 1ns/10ps
`include "adcc_params.svh"
module tb_top;
	import adcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq; // Clock, reset, APB
	logic [7:0] paddr, lat;
	logic [31:0] pwdata, prdata, rd;
	logic start_pin, pwm_centre, conv_ready, err; // Triggers and core
	logic [3:0] pwm_ch;
	logic [9:0] conv_result, value;
	adcc_core_req_t core_req;
	int fails, n_tests, n_start, n0, n_tick; // Counters
	adcc_top adcc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .external_start_pin(start_pin), .pwm_ch, .pwm_centre,
		.conv_ready, .conv_result, .core_req, .irq);
	adcc_core_model adcc_core_model_inst (.pclk, .presetn, .core_req, .lat, .value,
		.conv_ready, .conv_result);
	// Clock
	always #5 pclk = ~pclk;
	// Count starts sent to the core
	always @(posedge pclk) begin
		if (core_req.start === 1'h1) begin
			n_start++;
		end
	end
	// Count converter clock enables sent to the core
	always @(posedge pclk) begin
		if (core_req.clk_tick === 1'h1) begin
			n_tick++;
		end
	end
	// Count clock enables over 16 cycles, sampled away from the edge
	task automatic ticks(input int e);
		#1;
		n0 = n_tick;
		repeat (16) @(posedge pclk);
		#1;
		chk("ticks", n0 + e, n_tick);
		@(posedge pclk);
	endtask
	// One APB transfer, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// Compare a value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read and compare
	task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// Raise then drop trigger lines {centre, pwm, pin}
	task automatic pulse(input logic [5:0] m);
		{pwm_centre, pwm_ch, start_pin} <= m;
		repeat (8) @(posedge pclk);
		{pwm_centre, pwm_ch, start_pin} <= 6'h00;
		repeat (40) @(posedge pclk);
	endtask
	// Control word after a finished conversion
	function automatic logic [31:0] ctrl_x(logic [9:0] r, logic [2:0] c);
		return {24'h000000, r[1:0], 3'h2, c};
	endfunction
	// Verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#200us;
		fails++;
		finish_test();
	end
	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{start_pin, pwm_ch, pwm_centre, lat, value} = '0;
		void'($urandom(32'h4D826453));
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rdc(`ADCC_OFF_CFG, "cfg", `ADCC_CFG_RST);
		rdc(`ADCC_OFF_CTRL, "ctrl", 32'h0);
		rdc(8'h20, "unmapped", 32'h0);
		chk("slverr", 1'h1, err);
		apb(1'h1, `ADCC_OFF_IEN, 32'h1);
		// Every channel: result split, done, refusal, clear
		for (int c = 0; c < 8; c++) begin
			value <= 10'($urandom);
			lat <= 8'($urandom_range(40, 2));
			apb(1'h1, `ADCC_OFF_CTRL, 32'h08 | c);
			chk("channel", c, core_req.channel);
			@(posedge pclk iff conv_ready);
			repeat (2) @(posedge pclk);
			chk("irq", 1'h1, irq);
			rdc(`ADCC_OFF_RESH, "resh", value[9:2]);
			n0 = n_start;
			apb(1'h1, `ADCC_OFF_CTRL, 32'h18 | c);
			repeat (2) @(posedge pclk);
			chk("starts", n0, n_start);
			rdc(`ADCC_OFF_CTRL, "ctrl", ctrl_x(value, c));
			apb(1'h1, `ADCC_OFF_ICLR, 32'h1);
			@(posedge pclk);
			chk("irq", 1'h0, irq);
		end
		// Abort, masked event
		lat <= 8'hC8;
		apb(1'h1, `ADCC_OFF_CTRL, 32'h0D);
		rdc(`ADCC_OFF_CTRL, "busy", ctrl_x(value, 5) ^ 32'h18);
		apb(1'h1, `ADCC_OFF_CTRL, 32'h05);
		rdc(`ADCC_OFF_CTRL, "abort", ctrl_x(value, 5) ^ 32'h10);
		rdc(`ADCC_OFF_ISTAT, "istat", 32'h2);
		chk("irq", 1'h0, irq);
		// Pin start with trigger enable off, then on
		lat <= 8'h03;
		apb(1'h1, `ADCC_OFF_ENA, 32'h1);
		n0 = n_start;
		pulse(6'h01);
		chk("starts", n0, n_start);
		apb(1'h1, `ADCC_OFF_CTRL, 32'h20);
		pulse(6'h01);
		chk("starts", n0 + 1, n_start);
		// Falling edge of each selectable channel
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, `ADCC_OFF_ENA, 32'h0);
			apb(1'h1, `ADCC_OFF_CFG, 32'h60 | s);
			apb(1'h1, `ADCC_OFF_ENA, 32'h1);
			apb(1'h1, `ADCC_OFF_CTRL, 32'h20);
			n0 = n_start;
			pulse(6'h1E ^ (6'h02 << s));
			chk("starts", n0, n_start);
			pulse(6'h02 << s);
			chk("starts", n0 + 1, n_start);
		end
		// Type with upper bit low ignores PWM
		apb(1'h1, `ADCC_OFF_ENA, 32'h0);
		apb(1'h1, `ADCC_OFF_CFG, 32'h50);
		apb(1'h1, `ADCC_OFF_ENA, 32'h1);
		apb(1'h1, `ADCC_OFF_CTRL, 32'h20);
		n0 = n_start;
		pulse(6'h3E);
		chk("starts", n0, n_start);
		// Default divide by 2: one enable every second cycle
		ticks(8);
		// Centre-aligned point starts a conversion, divide by 1
		apb(1'h1, `ADCC_OFF_ENA, 32'h0);
		apb(1'h1, `ADCC_OFF_CFG, 32'h30);
		apb(1'h1, `ADCC_OFF_ENA, 32'h1);
		apb(1'h1, `ADCC_OFF_CTRL, 32'h20);
		n0 = n_start;
		pulse(6'h20);
		chk("starts", n0 + 1, n_start);
		ticks(16);
		finish_test();
	end
endmodule
